// ### include/ips_pkg.sv
// Package: constants for the interrupt priority level selector
package ips_pkg;
	localparam logic [7:0] LEVEL_REG_ADDR = 8'hb8;
	localparam logic [7:0] LEVEL_REG_RESET = 8'h80;
	localparam logic [7:0] LEVEL_RO_MASK = 8'h80;
	localparam logic [7:0] LEVEL_WR_MASK = 8'h7f;
	localparam int NUM_SRC = 7;
	localparam logic [2:0] BIT_ADDR_BASE = 3'h0;
	// Source index = bit position in the level register
	localparam int SRC_EXT_A = 0;
	localparam int SRC_TIMER0 = 1;
	localparam int SRC_EXT_B = 2;
	localparam int SRC_TIMER1 = 3;
	localparam int SRC_ASYNC = 4;
	localparam int SRC_TIMER2 = 5;
	localparam int SRC_SERIAL = 6;
	localparam int UNUSED_BIT = 7;
	localparam logic [2:0] NO_VECTOR = 3'h7;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOW = 3'b010,
		ST_HIGH = 3'b100
	} ips_state_t;
endpackage : ips_pkg

// ### logic/ips_level_select.sv
// Interrupt priority level register and two-level request arbiter
`timescale 1ns/100ps
// Contract
// R1: Level register sits at address 0xb8, bit addressable, resets to 0x80.
// R2: Bit 7 always reads one; writes to it are ignored.
// R3: Bit 6 selects serial peripheral level: zero low, one high.
// R4: Bit 5 selects timer 2 level: zero low, one high.
// R5: Bit 4 selects async serial port level: zero low, one high.
// R6: Bit 3 selects timer 1 level: zero low, one high.
// R7: Bit 2 selects external line b level: zero low, one high.
// R8: Bit 1 selects timer 0 level: zero low, one high.
// R9: Bit 0 selects external line a level: zero low, one high.
// R10: High level served first, preempts low handler; low never preempts.
module ips_level_select
	import ips_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rstn, // Async reset, active low
	input wire logic regWrEn, // Byte write strobe
	input wire logic regRdEn, // Byte read strobe
	input wire logic [7:0] regAddr, // Special-function address
	input wire logic [7:0] regWrData, // Byte write data
	input wire logic bitWrEn, // Single-bit write strobe
	input wire logic [2:0] bitSel, // Bit within level register
	input wire logic bitWrVal, // Value of single-bit write
	input wire logic [NUM_SRC-1:0] srcReq, // Pending source requests
	input wire logic globalEn, // Core allows interrupts
	input wire logic vecTaken, // Core entered handler
	input wire logic handlerDone, // Core returned from handler
	output logic [7:0] regRdData, // Read data, registered
	output logic regRdHit, // Read addressed this register
	output logic [NUM_SRC-1:0] srcLevel, // Per-source level, 1 = high
	output logic irqValid, // A request may be taken now
	output logic [2:0] irqVec, // Winning source index
	output logic irqHigh, // Winner is high level
	output logic inHigh, // High handler running
	output logic inLow // Low handler running
);
	logic [NUM_SRC-1:0] level_ff;
	logic [NUM_SRC-1:0] nxt_level;
	ips_state_t state_ff;
	ips_state_t nxt_state;
	logic lowSuspended_ff;
	logic hiFound;
	logic loFound;
	logic [2:0] hiIdx;
	logic [2:0] loIdx;
	logic addrHit;
	logic [7:0] levelView;

	////////////////////////////////////////////////////////////////////
	// Register write path

	assign addrHit = (regAddr == LEVEL_REG_ADDR); // [R1]

	// Byte writes drop bit 7; bit writes to bit 7 fall outside the loop
	generate
		for (genvar g = 0; g < NUM_SRC; g++) begin : g_lvl
			always_comb begin
				nxt_level[g] = level_ff[g];
				if (regWrEn && addrHit && LEVEL_WR_MASK[g])
					nxt_level[g] = regWrData[g]; // [R3] [R4] [R5]
				else if (bitWrEn && bitSel == 3'(g))
					nxt_level[g] = bitWrVal; // [R1] [R6] [R7]
			end
		end
	endgenerate

	// Level bits take their reset from the documented pattern
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			level_ff <= LEVEL_REG_RESET[NUM_SRC-1:0]; // [R1]
		else
			level_ff <= nxt_level; // [R8] [R9]
	end

	////////////////////////////////////////////////////////////////////
	// Register read path

	// Unused top bit is hard-wired so no flop can ever clear it
	assign levelView = {LEVEL_RO_MASK[UNUSED_BIT], level_ff}; // [R2]

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			regRdData <= 8'h00;
			regRdHit <= 1'b0;
		end else begin
			regRdHit <= regRdEn && addrHit;
			regRdData <= (regRdEn && addrHit) ? levelView : 8'h00; // [R2]
		end
	end

	// Level bits shown to the core straight from their flops
	assign srcLevel = level_ff; // [R3] [R9]

	////////////////////////////////////////////////////////////////////
	// Arbitration: split requests by level, pick within each

	ips_pick u_pick_hi (
		.req(srcReq & level_ff), // [R10]
		.found(hiFound),
		.idx(hiIdx)
	);

	ips_pick u_pick_lo (
		.req(srcReq & ~level_ff),
		.found(loFound),
		.idx(loIdx)
	);

	////////////////////////////////////////////////////////////////////
	// Handler nesting state
	// Low handler may be suspended under a high one; one level deep only

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (vecTaken && irqValid)
					nxt_state = irqHigh ? ST_HIGH : ST_LOW;
			end
			ST_LOW: begin
				if (vecTaken && irqValid && irqHigh)
					nxt_state = ST_HIGH; // [R10]
				else if (handlerDone)
					nxt_state = ST_IDLE;
			end
			ST_HIGH: begin
				if (handlerDone)
					nxt_state = lowSuspended_ff ? ST_LOW : ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Remember a preempted low handler so return resumes it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			lowSuspended_ff <= 1'b0;
		else if (state_ff == ST_LOW && nxt_state == ST_HIGH)
			lowSuspended_ff <= 1'b1; // [R10]
		else if (state_ff == ST_HIGH && handlerDone)
			lowSuspended_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Request offered to the core, registered

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqValid <= 1'b0;
			irqVec <= NO_VECTOR;
			irqHigh <= 1'b0;
		end else begin
			irqValid <= 1'b0;
			irqVec <= NO_VECTOR;
			irqHigh <= 1'b0;
			if (globalEn && !vecTaken && !handlerDone) begin
				// High wins over low; nothing preempts a high handler
				if (hiFound && nxt_state != ST_HIGH) begin
					irqValid <= 1'b1; // [R10]
					irqVec <= hiIdx;
					irqHigh <= 1'b1;
				end else if (loFound && nxt_state == ST_IDLE) begin
					irqValid <= 1'b1; // [R10]
					irqVec <= loIdx;
				end
			end
		end
	end

	// Handler status flags for the core
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			inHigh <= 1'b0;
			inLow <= 1'b0;
		end else begin
			inHigh <= (nxt_state == ST_HIGH);
			inLow <= (nxt_state == ST_LOW) ||
				(nxt_state == ST_HIGH && (lowSuspended_ff ||
				state_ff == ST_LOW));
		end
	end
endmodule : ips_level_select

// ### logic/ips_pick.sv
// Fixed-order picker: lowest numbered requesting source wins
`timescale 1ns/100ps
module ips_pick
	import ips_pkg::*;
(
	input wire logic [NUM_SRC-1:0] req, // Candidate requests
	output logic found, // Any candidate present
	output logic [2:0] idx // Index of winner
);
	// Scan from high index down so the lowest index is the last to win
	always_comb begin
		found = 1'b0;
		idx = NO_VECTOR;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				idx = 3'(i);
			end
		end
	end
endmodule : ips_pick

// ### sim/ips_chk_sva.sv
// Checker for the priority level selector
`timescale 1ns/100ps
module ips_chk
	import ips_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rstn, // Reset
	input wire logic regWrEn, // Byte write
	input wire logic regRdEn, // Byte read
	input wire logic [7:0] regAddr, // Address
	input wire logic [7:0] regWrData, // Write data
	input wire logic bitWrEn, // Bit write
	input wire logic [2:0] bitSel, // Bit number
	input wire logic bitWrVal, // Bit value
	input wire logic [NUM_SRC-1:0] srcReq, // Requests
	input wire logic [7:0] regRdData, // Read data
	input wire logic regRdHit, // Read hit
	input wire logic [NUM_SRC-1:0] srcLevel, // Levels
	input wire logic irqValid, // Offer
	input wire logic irqHigh, // Offer level
	input wire logic inHigh, // High handler
	input wire logic inLow // Low handler
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////
	// Register side
	AST_WR: assert property (regWrEn && regAddr == 8'hb8
		|=> srcLevel == $past(regWrData[6:0])) else $error("byte write");
	AST_RD: assert property (regRdEn && regAddr == 8'hb8
		|=> regRdHit && regRdData[7]) else $error("read hit");
	AST_MISS: assert property (regRdEn && regAddr != 8'hb8
		|=> !regRdHit && regRdData == 8'h00) else $error("miss");
	AST_BIT: assert property (bitWrEn && !regWrEn && bitSel < 3'h7
		|=> srcLevel[$past(bitSel)] == $past(bitWrVal)) else $error("bit");
	AST_B7: assert property (bitWrEn && !regWrEn && bitSel == 3'h7
		|=> $stable(srcLevel)) else $error("bit 7");
	////////////////////////////////////////////////////////////////////
	// Arbiter side: no offer in a high handler, no low offer in a low one, high never waits behind low
	AST_NOHI: assert property (irqValid |-> !inHigh)
		else $error("offer in high handler");
	AST_NOLO: assert property (irqValid && !irqHigh |-> !inLow)
		else $error("low preempts");
	AST_PRIO: assert property (irqValid && !irqHigh
		|-> ($past(srcReq) & $past(srcLevel)) == '0) else $error("prio");
	cover property (irqValid && irqHigh);
	cover property (inHigh && inLow);
	cover property (regRdHit);
endmodule : ips_chk
bind ips_level_select ips_chk u_chk(.*);

// ### sim/ips_core_model.sv
// Core model: takes offers and runs handlers
`timescale 1ns/100ps
module ips_core_model (
	input wire logic clk, // Clock
	input wire logic rstn, // Reset
	input wire logic irqValid, // Offer
	input wire logic [2:0] lat, // Handler length
	output logic vecTaken = 1'b0, // Accept pulse
	output logic handlerDone = 1'b0 // Return pulse
);
	logic [1:0] depthFf = 2'h0;
	logic [2:0] leftFf = 3'h0;
	// Depth allows one preemption; one return per accepted handler
	always @(negedge clk or negedge rstn) begin
		vecTaken <= 1'b0;
		handlerDone <= 1'b0;
		if (!rstn) begin
			depthFf <= 2'h0;
			leftFf <= 3'h0;
		end else if (irqValid && !vecTaken) begin
			vecTaken <= 1'b1;
			depthFf <= depthFf + 2'h1;
			leftFf <= lat;
		end else if (depthFf != 0 && leftFf == 0 && !handlerDone) begin
			handlerDone <= 1'b1;
			depthFf <= depthFf - 2'h1;
		end else if (leftFf != 0) begin
			leftFf <= leftFf - 3'h1;
		end
	end
endmodule : ips_core_model

// ### sim/test_interrupt_priority_select.sv
// Random bench for the priority level selector
`timescale 1ns/100ps
module test_interrupt_priority_select
	import ips_pkg::*;
;
	logic clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0, bitWrEn = 0;
	logic bitWrVal = 0, globalEn = 0, vecTaken, handlerDone;
	logic regRdHit, irqValid, irqHigh, inHigh, inLow;
	logic [7:0] regAddr = 0, regWrData = 0, regRdData;
	logic [2:0] bitSel = 0, irqVec, lat = 0;
	logic [NUM_SRC-1:0] srcReq = 0, srcLevel, lvl = 0;
	logic [31:0] seed = 32'h9e82;
	int nFail = 0, numChecks = 0;
	ips_level_select u_dut(.*);
	ips_core_model u_core(.*);
	////////////////////////////////////////////////////////////////////
	// Xorshift source, fixed start
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Expected {high, index}: high level first, then lowest index
	function logic [3:0] win(input logic [6:0] r, l);
		for (int i = 0; i < 7; i++) if (r[i] & l[i]) return {1'b1, 3'(i)};
		for (int i = 0; i < 7; i++) if (r[i]) return {1'b0, 3'(i)};
		return 4'h7;
	endfunction : win
	task chk(input logic [7:0] got, exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("unexpected %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task rd(input logic [7:0] a, exp);
		regRdEn = 1;
		regAddr = a;
		@(negedge clk);
		regRdEn = 0;
		chk(regRdData, exp);
		// Idle cycle so a following call never re-raises the strobe at once
		@(negedge clk);
	endtask : rd
	task testDone();
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : testDone
	////////////////////////////////////////////////////////////////////
	initial forever #2 clk = ~clk;
	// Watchdog, well past the expected run
	initial begin
		#8000;
		nFail++;
		testDone();
	end
	// Register access, then arbitration with random latency
	initial begin
		repeat (3) @(negedge clk);
		rstn = 1;
		rd(8'hb8, 8'h80);
		rd(8'hb7, 8'h00);
		for (int b = 0; b < 16; b++) begin
			regWrData = rnd();
			bitSel = 3'(b);
			bitWrVal = regWrData[0];
			regWrEn = b[3];
			bitWrEn = !b[3];
			regAddr = 8'hb8;
			@(negedge clk);
			{regWrEn, bitWrEn} = 0;
			if (b[3]) lvl = regWrData[6:0];
			else if (b < 7) lvl[b] = bitWrVal;
			chk(8'(srcLevel), 8'(lvl));
			rd(8'hb8, {1'b1, lvl});
		end
		globalEn = 1;
		repeat (20) begin
			lat = rnd();
			srcReq = rnd();
			repeat (3) if (!irqValid) @(negedge clk);
			chk({irqHigh, irqVec}, win(srcReq, lvl));
			chk(8'(irqValid), 8'(|srcReq));
			srcReq = 0;
			repeat (20) @(negedge clk);
		end
		// Corner: low handler running, then a high request preempts it
		regWrEn = 1;
		regAddr = 8'hb8;
		regWrData = 8'h01;
		lat = 3'h7;
		@(negedge clk);
		regWrEn = 0;
		lvl = 7'h01;
		srcReq = 7'h02;
		@(negedge clk);
		chk({irqHigh, irqVec}, win(srcReq, lvl));
		@(negedge clk);
		srcReq = 7'h03;
		@(negedge clk);
		chk({irqHigh, irqVec}, win(srcReq, lvl));
		chk(8'(inLow), 8'h01);
		srcReq = 0;
		repeat (40) @(negedge clk);
		chk({6'h00, inHigh, inLow}, 8'h00);
		testDone();
	end
endmodule : test_interrupt_priority_select
